// ==== alarm_ctl_consts.svh ====
`ifndef ALARM_CTL_CONSTS_SVH
`define ALARM_CTL_CONSTS_SVH

// ****************************************
// register offsets (byte address, low nibble)
// ****************************************
`define OFS_MIN_ALARM      4'h3
`define OFS_HOUR_ALARM     4'h5
`define OFS_DAY_ALARM      4'h7
`define OFS_ALARM_CTL_STAT 4'hB
`define OFS_WDOG_CENTI     4'hC
`define OFS_WDOG_SEC       4'hD

// ****************************************
// alarm_control_status bit positions
// ****************************************
`define BIT_UPDATE_XFER_EN 7
`define BIT_INT_PIN_SWAP   6
`define BIT_INTERRUPT_OUT_B_POLARITY  5
`define BIT_INT_PULSE_SEL  4
`define BIT_WDOG_IRQ_MASK  3
`define BIT_TOD_IRQ_MASK   2
`define BIT_WDOG_FLAG      1
`define BIT_TOD_FLAG       0
`define ALARM_MASK_BIT     7

// ****************************************
// reset values
// ****************************************
`define RST_ALARM_CTL      8'h8C
`define RST_ALARM_REG      8'h00
`define RST_WDOG_REG       8'h00

// ****************************************
// timing
// ****************************************
`define CORE_CLK_HZ        125000000
`define IRQ_PULSE_WIDTH_MS 3
`define MS_PER_S           1000

`endif

// ==== alarm_ctl_pkg.sv ====
package alarm_ctl_pkg;

  // ****************************************
  // command register layout
  // ****************************************
  typedef struct packed {
    logic update_transfer_enable;
    logic interrupt_pin_swap;
    logic interrupt_out_b_drive_polarity;
    logic interrupt_pulse_select;
    logic watchdog_irq_mask;
    logic tod_irq_mask;
    logic watchdog_alarm_flag;
    logic tod_alarm_flag;
  } alarm_ctl_t;

  // ****************************************
  // internal time, already incremented, bcd
  // ****************************************
  typedef struct packed {
    logic [7:0] seconds;
    logic [7:0] minutes;
    logic [7:0] hours;
    logic [7:0] days;
  } tod_time_t;

  // ****************************************
  // bus pins of the register port
  // ****************************************
  typedef struct packed {
    logic       ce_n;
    logic       oe_n;
    logic       we_n;
    logic [3:0] addr;
    logic [7:0] dq;
  } sram_bus_t;

endpackage : alarm_ctl_pkg

// ==== irq_flag_stage.sv ====
`timescale 1ns/100ps
`include "alarm_ctl_consts.svh"

module irq_flag_stage
  import alarm_ctl_pkg::*;
#(
  parameter int PULSE_CYCLES = 375000
) (
  input  wire logic i_core_clk,   // core clock
  input  wire logic i_sys_rst,    // async reset, high
  input  wire logic i_event,      // alarm occurred, one cycle
  input  wire logic i_clear,      // host touched alarm regs
  input  wire logic i_pulse_mode, // 1 pulse, 0 level
  output logic      o_flag        // flag and interrupt state
);

  localparam int CW = $clog2(PULSE_CYCLES + 1);
  localparam logic [CW-1:0] PULSE_LOAD = CW'(PULSE_CYCLES);

  logic [CW-1:0] cnt_r;
  logic [CW-1:0] cnt_nxt;
  logic          flag_r;
  logic          flag_nxt;
  wire           pulse_live = (cnt_r != '0);

  // ****************************************
  // pulse timer and flag
  // ****************************************
  // event beats a clear arriving in the same cycle
  assign cnt_nxt  = i_event ? PULSE_LOAD :
                    (i_clear || !pulse_live) ? '0 : cnt_r - CW'(1);           // R8
  assign flag_nxt = i_event ? 1'b1 :
                    i_clear ? 1'b0 :                                          // R22
                    i_pulse_mode ? (flag_r && (cnt_r > CW'(1))) : flag_r;     // R15

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      cnt_r  <= '0;
      flag_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      flag_r <= flag_nxt;
    end
  end

  assign o_flag = flag_r;

endmodule : irq_flag_stage

// ==== alarm_watchdog_irq_control.sv ====
`timescale 1ns/100ps
`include "alarm_ctl_consts.svh"
// What this block does
// R1 - minutes/hours/days mask bits choose per-minute, minute, hour+minute or full match
// R2 - host programs only the four listed mask combinations
// R3 - alarm/control/status register decoded at byte address 0Bh
// R4 - transfer enable low freezes host-visible clock registers; high resumes updates
// R5 - pin swap high: a is time-of-day, b watchdog; low exchanges them
// R6 - host never enables interrupt a and square wave together
// R7 - polarity bit: 1 sources only with supply present, 0 sinks
// R8 - pulse select: 0 level outputs, 1 pulses of at least 3 ms
// R9 - watchdog mask high holds watchdog interrupt inactive
// R10 - watchdog interrupt follows its flag, pulse mode, polarity and routing
// R11 - time-of-day mask high holds that interrupt inactive
// R12 - time-of-day interrupt follows its flag, pulse mode, polarity and routing
// R13 - watchdog flag is read-only, set on watchdog alarm
// R14 - any access to a watchdog register clears watchdog flag
// R15 - in pulse mode a flag reads one only during its pulse
// R16 - time-of-day flag is read-only, set on time-of-day alarm
// R17 - any access to a time-of-day alarm register clears that flag
// R18 - watchdog access reloads bcd countdown; zero raises alarm and repeats
// R19 - both watchdog registers zero disables the watchdog
// R20 - all masks set fires when seconds roll 59 to 00
// R21 - alarm checked at hundredths 99; transfer on 99 to 00 roll
// R22 - level mode interrupt holds until host access clears its flag
// R23 - writes to the two flag bit positions are ignored

module alarm_watchdog_irq_control
  import alarm_ctl_pkg::*;
#(
  parameter int PULSE_CYCLES =
    (`IRQ_PULSE_WIDTH_MS * `CORE_CLK_HZ + `MS_PER_S - 1) / `MS_PER_S
) (
  input  wire logic       i_core_clk,              // core clock, 125 MHz
  input  wire logic       i_sys_rst,               // async reset, high
  input  wire sram_bus_t  i_bus,                   // chip/output/write enables, addr, dq in
  output logic [7:0]      o_dq,                    // read data
  output logic            o_dq_oe,                 // read data drive enable
  input  wire tod_time_t  i_tod,                   // incremented internal time, bcd
  input  wire logic       i_hundredth_tick,        // one pulse per 0.01 s
  input  wire logic       i_hundredths_wrap,       // hundredths roll 99 to 00
  input  wire logic       i_vcc_present,           // main supply present
  output logic            o_transfer_strobe,       // copy internal to visible regs
  output logic            o_interrupt_out_a,       // pin a level while driven
  output logic            o_interrupt_out_a_oe,    // pin a drive enable
  output logic            o_interrupt_out_b,       // pin b level while driven
  output logic            o_interrupt_out_b_oe,    // pin b drive enable
  output alarm_ctl_t      o_ctl                    // control bits for the rest of the chip
);

  // ****************************************
  // bcd helpers
  // ****************************************
  function automatic logic [15:0] bcd_dec(input logic [15:0] v);
    logic [15:0] r;
    logic        borrow;
    r      = v;
    borrow = 1'b1;
    for (int i = 0; i < 4; i++) begin
      if (borrow) begin
        if (r[4*i +: 4] == 4'h0) begin
          r[4*i +: 4] = 4'h9;
        end else begin
          r[4*i +: 4] = r[4*i +: 4] - 4'h1;
          borrow      = 1'b0;
        end
      end
    end
    return r;
  endfunction : bcd_dec

  function automatic logic field_eq(input logic [7:0] a, input logic [7:0] b,
                                    input logic [7:0] keep);
    return ((a & keep) == (b & keep));
  endfunction : field_eq

  // ****************************************
  // bus cycle detection
  // ****************************************
  logic       rd_prev_r;
  logic       wr_prev_r;
  logic [3:0] wr_addr_r;
  logic [7:0] wr_data_r;

  wire rd_act    = !i_bus.ce_n && !i_bus.oe_n && i_bus.we_n;
  wire wr_act    = !i_bus.ce_n && !i_bus.we_n;
  wire rd_start  = rd_act && !rd_prev_r;
  wire wr_commit = wr_prev_r && !wr_act;

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      rd_prev_r <= 1'b0;
      wr_prev_r <= 1'b0;
      wr_addr_r <= 4'h0;
      wr_data_r <= 8'h00;
    end else begin
      rd_prev_r <= rd_act;
      wr_prev_r <= wr_act;
      if (wr_act) begin
        wr_addr_r <= i_bus.addr;
        wr_data_r <= i_bus.dq;
      end
    end
  end

  // ****************************************
  // address decode
  // ****************************************
  wire hit_min_rd  = rd_start  && (i_bus.addr == `OFS_MIN_ALARM);
  wire hit_hour_rd = rd_start  && (i_bus.addr == `OFS_HOUR_ALARM);
  wire hit_day_rd  = rd_start  && (i_bus.addr == `OFS_DAY_ALARM);
  wire hit_wlo_rd  = rd_start  && (i_bus.addr == `OFS_WDOG_CENTI);
  wire hit_whi_rd  = rd_start  && (i_bus.addr == `OFS_WDOG_SEC);
  wire wr_min      = wr_commit && (wr_addr_r == `OFS_MIN_ALARM);
  wire wr_hour     = wr_commit && (wr_addr_r == `OFS_HOUR_ALARM);
  wire wr_day      = wr_commit && (wr_addr_r == `OFS_DAY_ALARM);
  wire wr_ctl      = wr_commit && (wr_addr_r == `OFS_ALARM_CTL_STAT);         // R3
  wire wr_wlo      = wr_commit && (wr_addr_r == `OFS_WDOG_CENTI);
  wire wr_whi      = wr_commit && (wr_addr_r == `OFS_WDOG_SEC);

  wire tod_access  = hit_min_rd || hit_hour_rd || hit_day_rd ||
                     wr_min || wr_hour || wr_day;                             // R17
  wire wdog_access = hit_wlo_rd || hit_whi_rd || wr_wlo || wr_whi;            // R14

  // ****************************************
  // stored registers
  // ****************************************
  logic [7:0] min_alarm_r;
  logic [7:0] hour_alarm_r;
  logic [7:0] day_alarm_r;
  logic [7:0] wdog_centi_r;
  logic [7:0] wdog_sec_r;
  logic [5:0] ctl_bits_r;

  // day alarm keeps its mask bit and three day bits; the rest read zero
  wire [7:0] day_keep = 8'h87;

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      min_alarm_r  <= `RST_ALARM_REG;
      hour_alarm_r <= `RST_ALARM_REG;
      day_alarm_r  <= `RST_ALARM_REG;
      wdog_centi_r <= `RST_WDOG_REG;
      wdog_sec_r   <= `RST_WDOG_REG;
      ctl_bits_r   <= 6'(`RST_ALARM_CTL >> 2);
    end else begin
      if (wr_min)  min_alarm_r  <= wr_data_r;
      if (wr_hour) hour_alarm_r <= wr_data_r;
      if (wr_day)  day_alarm_r  <= wr_data_r & day_keep;
      if (wr_wlo)  wdog_centi_r <= wr_data_r;
      if (wr_whi)  wdog_sec_r   <= wr_data_r;
      if (wr_ctl)  ctl_bits_r   <= wr_data_r[7:2];                            // R23
    end
  end

  wire xfer_en    = ctl_bits_r[`BIT_UPDATE_XFER_EN - 2];
  wire pin_swap   = ctl_bits_r[`BIT_INT_PIN_SWAP - 2];
  wire b_polarity = ctl_bits_r[`BIT_INTERRUPT_OUT_B_POLARITY - 2];
  wire pulse_sel  = ctl_bits_r[`BIT_INT_PULSE_SEL - 2];
  wire wdog_mask  = ctl_bits_r[`BIT_WDOG_IRQ_MASK - 2];
  wire tod_mask   = ctl_bits_r[`BIT_TOD_IRQ_MASK - 2];

  // ****************************************
  // time-of-day alarm compare
  // ****************************************
  wire [2:0] masks    = {min_alarm_r[`ALARM_MASK_BIT],
                         hour_alarm_r[`ALARM_MASK_BIT],
                         day_alarm_r[`ALARM_MASK_BIT]};
  wire       sec_zero = (i_tod.seconds == 8'h00);
  wire       min_eq   = field_eq(i_tod.minutes, min_alarm_r, 8'h7F);
  wire       hour_eq  = field_eq(i_tod.hours, hour_alarm_r, 8'h7F);
  wire       day_eq   = field_eq(i_tod.days, day_alarm_r, 8'h07);

  logic tod_match;
  always_comb begin
    unique case (masks)
      3'b111:  tod_match = sec_zero;                                          // R20
      3'b011:  tod_match = sec_zero && min_eq;                                // R1
      3'b001:  tod_match = sec_zero && min_eq && hour_eq;                     // R1
      3'b000:  tod_match = sec_zero && min_eq && hour_eq && day_eq;           // R1
      default: tod_match = 1'b0;                                              // R2
    endcase
  end

  wire tod_event = i_hundredths_wrap && tod_match;                           // R21

  // ****************************************
  // watchdog countdown
  // ****************************************
  logic [15:0] wdog_cnt_r;
  logic [15:0] wdog_cnt_nxt;
  logic        wdog_event_r;

  // an access still in flight on the bus uses the value about to land
  wire [7:0]  reload_centi = wr_wlo ? wr_data_r : wdog_centi_r;
  wire [7:0]  reload_sec   = wr_whi ? wr_data_r : wdog_sec_r;
  wire [15:0] reload_val   = {reload_sec, reload_centi};
  wire        wdog_off     = ({wdog_sec_r, wdog_centi_r} == 16'h0000);        // R19
  wire        cnt_at_one   = (wdog_cnt_r == 16'h0001);
  wire        wdog_fire    = !wdog_off && !wdog_access &&
                             i_hundredth_tick && cnt_at_one;                  // R18

  always_comb begin
    wdog_cnt_nxt = wdog_cnt_r;
    if (wdog_access) begin
      wdog_cnt_nxt = reload_val;                                              // R18
    end else if (wdog_off) begin
      wdog_cnt_nxt = 16'h0000;                                                // R19
    end else if (i_hundredth_tick) begin
      wdog_cnt_nxt = (cnt_at_one || wdog_cnt_r == 16'h0000) ?
                     {wdog_sec_r, wdog_centi_r} : bcd_dec(wdog_cnt_r);        // R18
    end
  end

  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wdog_cnt_r   <= 16'h0000;
      wdog_event_r <= 1'b0;
    end else begin
      wdog_cnt_r   <= wdog_cnt_nxt;
      wdog_event_r <= wdog_fire;
    end
  end

  // ****************************************
  // flags and interrupt timing
  // ****************************************
  logic tod_flag;
  logic wdog_flag;

  irq_flag_stage #(
    .PULSE_CYCLES (PULSE_CYCLES)
  ) u_tod_flag (
    .i_core_clk   (i_core_clk),
    .i_sys_rst    (i_sys_rst),
    .i_event      (tod_event),                                                // R16
    .i_clear      (tod_access),                                               // R17
    .i_pulse_mode (pulse_sel),
    .o_flag       (tod_flag)
  );

  irq_flag_stage #(
    .PULSE_CYCLES (PULSE_CYCLES)
  ) u_wdog_flag (
    .i_core_clk   (i_core_clk),
    .i_sys_rst    (i_sys_rst),
    .i_event      (wdog_event_r),                                             // R13
    .i_clear      (wdog_access),                                              // R14
    .i_pulse_mode (pulse_sel),
    .o_flag       (wdog_flag)
  );

  // ****************************************
  // interrupt routing and pin drive
  // ****************************************
  wire tod_irq  = tod_flag && !tod_mask;                                      // R11 R12
  wire wdog_irq = wdog_flag && !wdog_mask;                                    // R9 R10
  wire a_active = pin_swap ? tod_irq : wdog_irq;                              // R5
  wire b_active = pin_swap ? wdog_irq : tod_irq;                              // R5

  // a is open drain, pulled low while active
  assign o_interrupt_out_a    = 1'b0;
  assign o_interrupt_out_a_oe = a_active;
  // b sources high only with supply when polarity is 1; sinks low when polarity is 0
  assign o_interrupt_out_b    = b_polarity;                                   // R7
  assign o_interrupt_out_b_oe = b_active && (!b_polarity || i_vcc_present);   // R7

  // ****************************************
  // read path and status outputs
  // ****************************************
  alarm_ctl_t ctl_view;
  assign ctl_view = {ctl_bits_r, wdog_flag, tod_flag};                        // R13 R16

  logic [7:0] rd_mux;
  logic       rd_hit;
  always_comb begin
    rd_hit = 1'b1;
    unique case (i_bus.addr)
      `OFS_MIN_ALARM:      rd_mux = min_alarm_r;
      `OFS_HOUR_ALARM:     rd_mux = hour_alarm_r;
      `OFS_DAY_ALARM:      rd_mux = day_alarm_r;
      `OFS_ALARM_CTL_STAT: rd_mux = ctl_view;                                 // R3
      `OFS_WDOG_CENTI:     rd_mux = wdog_centi_r;
      `OFS_WDOG_SEC:       rd_mux = wdog_sec_r;
      default: begin
        rd_mux = 8'h00;
        rd_hit = 1'b0;
      end
    endcase
  end

  logic [7:0] dq_r;
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      dq_r <= 8'h00;
    end else begin
      dq_r <= rd_mux;
    end
  end

  assign o_dq              = dq_r;
  assign o_dq_oe           = rd_act && rd_prev_r && rd_hit;
  assign o_transfer_strobe = i_hundredths_wrap && xfer_en;                    // R4 R21
  assign o_ctl             = ctl_view;

endmodule : alarm_watchdog_irq_control

// ==== alarm_ctl_assertions.sv ====
`timescale 1ns/100ps
`include "alarm_ctl_consts.svh"

module alarm_ctl_assertions
  import alarm_ctl_pkg::*;
#(
  parameter int PULSE_CYCLES = 8
) (
  input wire logic       i_core_clk,           // core clock
  input wire logic       i_sys_rst,            // async reset
  input wire sram_bus_t  i_bus,                // host bus
  input wire logic       i_hundredth_tick,     // watchdog tick
  input wire logic       i_hundredths_wrap,    // alarm check
  input wire logic       i_vcc_present,        // main supply
  input wire logic       o_transfer_strobe,    // copy strobe
  input wire logic       o_interrupt_out_a,    // pin a level
  input wire logic       o_interrupt_out_a_oe, // pin a active
  input wire logic       o_interrupt_out_b,    // pin b level
  input wire logic       o_interrupt_out_b_oe, // pin b active
  input wire alarm_ctl_t o_ctl                 // command view
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_sys_rst);

  // ****************************************
  // write tracking, tod flag run length
  // ****************************************
  logic       wr_now;
  logic       rd_now;
  logic       wr_r;
  logic [3:0] a_r;
  logic [7:0] d_r;
  logic [7:0] cw_r;
  int         cnt_r;
  assign wr_now = !i_bus.ce_n && !i_bus.we_n;
  assign rd_now = !i_bus.ce_n && !i_bus.oe_n && i_bus.we_n;
  always_ff @(posedge i_core_clk or posedge i_sys_rst) begin
    if (i_sys_rst) begin
      wr_r  <= 1'b0;
      a_r   <= 4'h0;
      d_r   <= 8'h00;
      cw_r  <= `RST_ALARM_CTL;
      cnt_r <= 0;
    end else begin
      wr_r  <= wr_now;
      a_r   <= i_bus.addr;
      d_r   <= i_bus.dq;
      cnt_r <= o_ctl.tod_alarm_flag ? cnt_r + 1 : 0;
      if (wr_r && !wr_now && a_r == 4'hB) begin
        cw_r <= d_r;
      end
    end
  end

  chk_xfer_gate: assert property (o_transfer_strobe ==
    (i_hundredths_wrap && o_ctl.update_transfer_enable)) else $error("transfer gate wrong");
  chk_ctl_write: assert property (wr_r && !wr_now && a_r == 4'hB
    |-> ##[1:2] o_ctl[7:2] == cw_r[7:2]) else $error("command write lost");
  chk_tod_set: assert property ($rose(o_ctl.tod_alarm_flag)
    |-> $past(i_hundredths_wrap)) else $error("tod flag set without alarm");
  chk_wdog_set: assert property ($rose(o_ctl.watchdog_alarm_flag)
    |-> $past(i_hundredth_tick, 2) || $past(i_hundredth_tick, 3)) else $error("wd flag stray");
  chk_tod_route: assert property (o_ctl.interrupt_pin_swap |-> o_interrupt_out_a_oe ==
    (o_ctl.tod_alarm_flag && !o_ctl.tod_irq_mask)) else $error("pin a not tod");
  chk_wdog_route: assert property (!o_ctl.interrupt_pin_swap |-> o_interrupt_out_a_oe ==
    (o_ctl.watchdog_alarm_flag && !o_ctl.watchdog_irq_mask)) else $error("pin a not wd");
  chk_a_sinks: assert property (o_interrupt_out_a == 1'b0) else $error("pin a drives high");
  chk_b_drive: assert property (o_interrupt_out_b_oe |-> o_interrupt_out_b ==
    o_ctl.interrupt_out_b_drive_polarity && (i_vcc_present || !o_ctl.interrupt_out_b_drive_polarity))
    else $error("pin b drive wrong");
  chk_pulse_len: assert property (o_ctl.interrupt_pulse_select
    |-> cnt_r <= PULSE_CYCLES) else $error("pulse too long");
  chk_tod_clear: assert property (rd_now && i_bus.addr inside {4'h3, 4'h5, 4'h7}
    && !$past(rd_now) && !i_hundredths_wrap |-> ##[1:2] !o_ctl.tod_alarm_flag)
    else $error("tod flag kept");
  chk_wdog_clear: assert property (rd_now && i_bus.addr inside {4'hC, 4'hD}
    && !$past(rd_now) && !$past(i_hundredth_tick) && !i_hundredth_tick
    |-> ##[1:2] !o_ctl.watchdog_alarm_flag) else $error("wd flag kept");
endmodule : alarm_ctl_assertions

bind alarm_watchdog_irq_control alarm_ctl_assertions #(.PULSE_CYCLES(PULSE_CYCLES)) i_chk (
  .i_core_clk(i_core_clk), .i_sys_rst(i_sys_rst), .i_bus(i_bus),
  .i_hundredth_tick(i_hundredth_tick), .i_hundredths_wrap(i_hundredths_wrap),
  .i_vcc_present(i_vcc_present), .o_transfer_strobe(o_transfer_strobe),
  .o_interrupt_out_a(o_interrupt_out_a), .o_interrupt_out_a_oe(o_interrupt_out_a_oe),
  .o_interrupt_out_b(o_interrupt_out_b), .o_interrupt_out_b_oe(o_interrupt_out_b_oe),
  .o_ctl(o_ctl));

// ==== host_bus_model.sv ====
`timescale 1ns/100ps

module host_bus_model
  import alarm_ctl_pkg::*;
(
  input  wire logic       i_core_clk, // core clock
  input  wire logic [7:0] i_dq,       // read data
  input  wire logic       i_dq_oe,    // read data driven
  output sram_bus_t       o_bus       // host bus pins
);
  initial o_bus = '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: 4'h0, dq: 8'h00};

  // released lines flip so stale values never look valid
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge i_core_clk);
    o_bus <= '{ce_n: 1'b0, oe_n: 1'b1, we_n: 1'b0, addr: a, dq: d};
    @(posedge i_core_clk);
    o_bus <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: ~a, dq: ~d};
    @(posedge i_core_clk);
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] d, output logic oe);
    @(posedge i_core_clk);
    o_bus <= '{ce_n: 1'b0, oe_n: 1'b0, we_n: 1'b1, addr: a, dq: ~o_bus.dq};
    repeat (2) @(posedge i_core_clk);
    d = i_dq;
    oe = i_dq_oe;
    o_bus <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, addr: ~a, dq: ~o_bus.dq};
  endtask : rd
endmodule : host_bus_model

// ==== alarm_watchdog_irq_control_tb.sv ====
`timescale 1ns/100ps

module alarm_watchdog_irq_control_tb;
  import alarm_ctl_pkg::*;
  localparam int PW = 8;
  logic       clk, rst, tick, wrap, vcc, dq_oe, strobe, a, a_oe, b, b_oe;
  logic [7:0] dq;
  sram_bus_t  bus;
  tod_time_t  tod;
  alarm_ctl_t ctl;
  int         miscompares, cmp_count;

  alarm_watchdog_irq_control #(.PULSE_CYCLES(PW)) i_dut (
    .i_core_clk(clk), .i_sys_rst(rst), .i_bus(bus), .o_dq(dq), .o_dq_oe(dq_oe),
    .i_tod(tod), .i_hundredth_tick(tick), .i_hundredths_wrap(wrap), .i_vcc_present(vcc),
    .o_transfer_strobe(strobe), .o_interrupt_out_a(a), .o_interrupt_out_a_oe(a_oe),
    .o_interrupt_out_b(b), .o_interrupt_out_b_oe(b_oe), .o_ctl(ctl));
  host_bus_model i_host (.i_core_clk(clk), .i_dq(dq), .i_dq_oe(dq_oe), .o_bus(bus));

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic conclude;
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : conclude

  task automatic fire(input logic [7:0] s, m, h, d, output logic st);
    @(posedge clk);
    tod  <= '{seconds: s, minutes: m, hours: h, days: d};
    wrap <= 1'b1;
    #1 st = strobe;
    @(posedge clk);
    wrap <= 1'b0;
    #1;
  endtask : fire

  task automatic ticks(input int n);
    repeat (n) begin
      @(posedge clk);
      tick <= 1'b1;
      @(posedge clk);
      tick <= 1'b0;
    end
    repeat (2) @(posedge clk);
    #1;
  endtask : ticks

  task automatic t_regs;
    logic [7:0] d;
    logic oe, st;
    i_host.rd(4'hB, d, oe);
    chk("ctl reset", d, 8'h8C);
    chk("ctl oe", {7'h00, oe}, 8'h01);
    i_host.rd(4'hE, d, oe);
    chk("unmapped oe", {7'h00, oe}, 8'h00);
    i_host.wr(4'hB, 8'hFF);
    i_host.rd(4'hB, d, oe);
    chk("ctl flags ro", d, 8'hFC);
    fire(8'h01, 8'h00, 8'h00, 8'h00, st);
    chk("strobe on", {7'h00, st}, 8'h01);
    i_host.wr(4'hB, 8'h0C);
    fire(8'h01, 8'h00, 8'h00, 8'h00, st);
    chk("strobe frozen", {7'h00, st}, 8'h00);
  endtask : t_regs

  task automatic t_modes;
    logic [7:0] d;
    logic oe, st;
    for (int i = 0; i < 4; i++) begin
      // only the four listed mask combinations are programmed
      i_host.wr(4'h3, {i == 0, 7'h30});
      i_host.wr(4'h5, {i < 2, 7'h12});
      i_host.wr(4'h7, {i < 3, 7'h03});
      // masked fields carry values that differ from the stored alarm
      fire(8'h00, (i > 0) ? 8'h30 : 8'h45, (i > 1) ? 8'h12 : 8'h07,
           (i == 3) ? 8'h03 : 8'h05, st);
      chk("tod match", {7'h00, ctl.tod_alarm_flag}, 8'h01);
      i_host.rd((i == 1) ? 4'h5 : (i == 2) ? 4'h7 : 4'h3, d, oe);
      chk("tod clear", {7'h00, ctl.tod_alarm_flag}, 8'h00);
      fire({7'h00, i == 0}, {7'h18, i == 1}, {7'h09, i == 2}, {7'h01, i != 3}, st);
      chk("tod miss", {7'h00, ctl.tod_alarm_flag}, 8'h00);
    end
  endtask : t_modes

  task automatic t_pins;
    logic [7:0] d;
    logic oe, st;
    i_host.wr(4'hB, 8'hC0); // square wave kept off here
    fire(8'h00, 8'h30, 8'h12, 8'h03, st);
    repeat (4) @(posedge clk);
    #1;
    chk("pin a tod", {5'h00, a_oe, b_oe, a}, 8'h04);
    i_host.rd(4'h3, d, oe);
    i_host.wr(4'hB, 8'hA0);
    fire(8'h00, 8'h30, 8'h12, 8'h03, st);
    chk("pin b source", {5'h00, a_oe, b_oe, b}, 8'h03);
    @(posedge clk);
    vcc <= 1'b0;
    #1;
    chk("pin b no supply", {7'h00, b_oe}, 8'h00);
    @(posedge clk);
    vcc <= 1'b1;
    i_host.rd(4'h5, d, oe);
    i_host.wr(4'hB, 8'hA4);
    fire(8'h00, 8'h30, 8'h12, 8'h03, st);
    chk("tod masked", {6'h00, ctl.tod_alarm_flag, b_oe}, 8'h02);
    i_host.rd(4'h7, d, oe);
  endtask : t_pins

  task automatic t_wdog;
    logic [7:0] d;
    logic oe;
    i_host.wr(4'hB, 8'h80);
    i_host.wr(4'hC, 8'h02);
    i_host.wr(4'hD, 8'h00);
    ticks(1);
    chk("wd early", {6'h00, ctl.watchdog_alarm_flag, a_oe}, 8'h00);
    ticks(1);
    chk("wd fire", {6'h00, ctl.watchdog_alarm_flag, a_oe}, 8'h03);
    i_host.rd(4'hC, d, oe);
    chk("wd value", d, 8'h02);
    chk("wd clear", {6'h00, ctl.watchdog_alarm_flag, a_oe}, 8'h00);
    i_host.wr(4'hB, 8'h88);
    ticks(2);
    chk("wd masked", {6'h00, ctl.watchdog_alarm_flag, a_oe}, 8'h02);
    i_host.rd(4'hD, d, oe);
    i_host.wr(4'hC, 8'h00);
    i_host.wr(4'hD, 8'h00);
    ticks(3);
    chk("wd off", {7'h00, ctl.watchdog_alarm_flag}, 8'h00);
  endtask : t_wdog

  task automatic t_pulse;
    logic st;
    i_host.wr(4'hB, 8'hD0);
    fire(8'h00, 8'h30, 8'h12, 8'h03, st);
    chk("pulse on", {6'h00, ctl.tod_alarm_flag, a_oe}, 8'h03);
    repeat (PW - 2) @(posedge clk);
    #1;
    chk("pulse held", {6'h00, ctl.tod_alarm_flag, a_oe}, 8'h03);
    repeat (2) @(posedge clk);
    #1;
    chk("pulse end", {6'h00, ctl.tod_alarm_flag, a_oe}, 8'h00);
  endtask : t_pulse

  initial begin
    miscompares = 0;
    cmp_count = 0;
    rst = 1'b1;
    tick = 1'b0;
    wrap = 1'b0;
    vcc = 1'b1;
    tod = '{seconds: 8'h01, default: 8'h00};
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_modes();
    t_pins();
    t_wdog();
    t_pulse();
    conclude();
  end

  initial begin
    #100000;
    miscompares++;
    conclude();
  end
endmodule : alarm_watchdog_irq_control_tb
